// ===== host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the link: a step line that idles low between bursts, plus anodes.
module host_port_model (
   output logic       o_step,
   output logic [6:0] o_anode
);
   // The step line rests low so that no stray edge advances the scan.
   initial
   begin
      o_step  = 1'b0;
      o_anode = 7'h00;
   end
   // One rising edge per count at a 48 ns period; it stands still afterwards.
   task automatic step(input int n);
      repeat (n)
      begin
         #24 o_step = 1'b1;
         #24 o_step = 1'b0;
      end
   endtask
   // Pattern for the position that the next edge selects, bit 6 is line a.
   task automatic show(input logic [6:0] v);
      o_anode = v;
   endtask
endmodule
`default_nettype wire

// ===== kdu_pkg.sv
// Shared constants for the keypad and display scanner.
package scan_pkg;

   // Main clock period and the idle time after which the scan is parked.
   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned IDLE_TIMEOUT_NS = 7_500_000;
   // Longest time, so the cycle count rounds down.
   localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int          IDLE_W           = 21;

   // Scan counter geometry and the counts that carry meaning.
   localparam int         COUNT_W     = 4;
   localparam int         SCAN_N      = 16;
   localparam logic [3:0] COUNT_FIRST = 4'h0;
   localparam logic [3:0] COUNT_DIGIT_LAST = 4'h8;
   localparam logic [3:0] COUNT_LED   = 4'h9;
   localparam logic [3:0] COUNT_LAST  = 4'hF;
   localparam logic [3:0] COUNT_STEP  = 4'h1;

   // Keypad matrix and anode widths.
   localparam int KEY_COLS = 8;
   localparam int KEY_ROWS = 4;
   localparam int KEY_N    = 32;
   localparam int SEG_W    = 7;
   localparam int LED_W    = 5;

   // Reset values.
   localparam logic [15:0] SCAN_RESET_N = 16'h7FFF;
   localparam logic [3:0]  ROWS_IDLE    = 4'hF;

endpackage

// ===== kdu_scanner.sv
// Notes on behaviour
// - Eight host lines in, six sense lines out, plus supply and ground.
// - Sixteen-state counter, active-low outputs, exactly one asserted for the count.
// - Each step line rising edge advances the counter by one position.
// - From count 15 the next step edge wraps to count 0.
// - No step edge for 7.5 ms blanks all digit and LED cathodes.
// - Timeout parks the counter at 15 until the next step edge.
// - Counts 0 to 8 select the cathode of the digit with that index.
// - Count 9 selects the common cathode of the five mode LEDs.
// - Scan origin flag is low while the count is 0.
// - Anode lines a..g drive segments A..G; a..e also drive mode LEDs.
// - High anode lights the selected segment or LED, low leaves it dark.
// - Keypad is 8 columns by 4 rows, columns are counts 0 to 7.
// - Pressed key pulls its row low while its column is selected.
// - Run/halt switch reads directly on the fifth sense line, low for halt.
`timescale 1ns/1ps
`default_nettype none
module keypad_display_scanner #(
   parameter int unsigned IDLE_LIMIT = scan_pkg::IDLE_TIMEOUT_CYC
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic        i_scan_step_line,
   input  wire logic        i_anode_line_a,
   input  wire logic        i_anode_line_b,
   input  wire logic        i_anode_line_c,
   input  wire logic        i_anode_line_d,
   input  wire logic        i_anode_line_e,
   input  wire logic        i_anode_line_f,
   input  wire logic        i_anode_line_g,
   input  wire logic [31:0] i_key_closed,
   input  wire logic        i_run_position,
   output logic             o_key_row_0,
   output logic             o_key_row_1,
   output logic             o_key_row_2,
   output logic             o_key_row_3,
   output logic             o_run_halt_sense,
   output logic             o_scan_origin_flag,
   output logic [15:0]      o_scan_output_n,
   output logic [6:0]       o_segment_anode,
   output logic [4:0]       o_led_anode
);

   typedef struct packed {
      logic [31:0] key_s1;
      logic [31:0] key_s2;
      logic [6:0]  anode_s1;
      logic [6:0]  anode_s2;
      logic        run_s1;
      logic        run_s2;
      logic [3:0]  count;
      logic [15:0] scan_n;
      logic [3:0]  rows;
      logic        run;
      logic        origin;
      logic [6:0]  anode;
   } scan_t;

   scan_t q;
   scan_t d;

   scan_evt_if evt ();

   // Active-low one-of-sixteen decode of a count.
   function automatic logic [15:0] onehot_n(input logic [3:0] cnt);
      onehot_n = ~(16'h0001 << cnt);
   endfunction

   step_watch #(
      .IDLE_LIMIT (IDLE_LIMIT)
   ) u_watch (
      .i_mclk      (i_mclk),
      .i_rstn      (i_rstn),
      .i_step_line (i_scan_step_line),
      .evt         (evt)
   );

   // Next state: resync the pins, step or park the counter, then decode from the new count.
   // Rows are decoded from the new count so they change in the same cycle as the columns.
   always_comb
   begin
      d          = q;
      d.key_s1   = i_key_closed;
      d.key_s2   = q.key_s1;
      d.anode_s1 = {i_anode_line_a, i_anode_line_b, i_anode_line_c, i_anode_line_d,
                    i_anode_line_e, i_anode_line_f, i_anode_line_g};
      d.anode_s2 = q.anode_s1;
      d.run_s1   = i_run_position;
      d.run_s2   = q.run_s1;
      if (evt.time_out)
      begin
         d.count = scan_pkg::COUNT_LAST;
      end
      else if (evt.step_rise)
      begin
         d.count = 4'(q.count + scan_pkg::COUNT_STEP);
      end
      d.scan_n = onehot_n(d.count);
      for (int r = 0; r < scan_pkg::KEY_ROWS; r++)
      begin
         d.rows[r] = !(d.count < 4'(scan_pkg::KEY_COLS) &&
                       q.key_s2[{d.count[2:0], 2'(r)}]);
      end
      d.origin = (d.count != scan_pkg::COUNT_FIRST);
      d.run    = q.run_s2;
      d.anode  = q.anode_s2;
   end

   // Only the constants are loaded at reset; the counter starts parked.
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         q        <= '0;
         q.count  <= scan_pkg::COUNT_LAST;
         q.scan_n <= scan_pkg::SCAN_RESET_N;
         q.rows   <= scan_pkg::ROWS_IDLE;
         q.origin <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // All outputs are flip-flop bits; the LED anodes are the top five anode lines.
   assign o_key_row_0        = q.rows[0];
   assign o_key_row_1        = q.rows[1];
   assign o_key_row_2        = q.rows[2];
   assign o_key_row_3        = q.rows[3];
   assign o_run_halt_sense   = q.run;
   assign o_scan_origin_flag = q.origin;
   assign o_scan_output_n    = q.scan_n;
   assign o_segment_anode    = q.anode;
   assign o_led_anode        = q.anode[6:2];

   // Checks on the scan behaviour.
   property p_onehot;
      @(posedge i_mclk) disable iff (!i_rstn)
      $onehot(~o_scan_output_n) && o_scan_output_n == onehot_n(q.count);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("Scan outputs are not one active-low line for the count.");

   property p_step;
      @(posedge i_mclk) disable iff (!i_rstn)
      (evt.step_rise && !evt.time_out) |=> q.count == 4'($past(q.count) + 4'h1);
   endproperty
   a_step: assert property (p_step)
      else $error("Step edge did not advance the counter by one.");

   property p_wrap;
      @(posedge i_mclk) disable iff (!i_rstn)
      (evt.step_rise && q.count == scan_pkg::COUNT_LAST) |=> q.count == scan_pkg::COUNT_FIRST;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Counter did not wrap from 15 to 0.");

   property p_park;
      @(posedge i_mclk) disable iff (!i_rstn)
      evt.time_out |=> (q.count == scan_pkg::COUNT_LAST && &o_scan_output_n[9:0]);
   endproperty
   a_park: assert property (p_park)
      else $error("Timeout did not park the counter with cathodes off.");

   property p_hold;
      @(posedge i_mclk) disable iff (!i_rstn)
      (q.count == scan_pkg::COUNT_LAST && !evt.step_rise) |=> q.count == scan_pkg::COUNT_LAST;
   endproperty
   a_hold: assert property (p_hold)
      else $error("Parked counter moved without a step edge.");

   property p_digit;
      @(posedge i_mclk) disable iff (!i_rstn)
      (q.count <= scan_pkg::COUNT_DIGIT_LAST) |-> !o_scan_output_n[q.count];
   endproperty
   a_digit: assert property (p_digit)
      else $error("Digit cathode not selected for its count.");

   property p_led;
      @(posedge i_mclk) disable iff (!i_rstn)
      !o_scan_output_n[9] |-> q.count == scan_pkg::COUNT_LED;
   endproperty
   a_led: assert property (p_led)
      else $error("LED common cathode selected outside count 9.");

   property p_origin;
      @(posedge i_mclk) disable iff (!i_rstn)
      o_scan_origin_flag == (q.count != scan_pkg::COUNT_FIRST);
   endproperty
   a_origin: assert property (p_origin)
      else $error("Scan origin flag disagrees with the count.");

   property p_row_idle;
      @(posedge i_mclk) disable iff (!i_rstn)
      (q.count >= 4'(scan_pkg::KEY_COLS)) |->
      (o_key_row_0 && o_key_row_1 && o_key_row_2 && o_key_row_3);
   endproperty
   a_row_idle: assert property (p_row_idle)
      else $error("Row sensed low while no keypad column was selected.");

   property p_run;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_run_position ##1 i_run_position ##1 i_run_position) |=> o_run_halt_sense;
   endproperty
   a_run: assert property (p_run)
      else $error("Run position not reported high on the fifth sense line.");

   // Further checks on pin timing, on the watcher's events and on the decoded scan.
   // Halt must read low as well, so a stuck-high sense line is caught.
   property p_halt;
      @(posedge i_mclk) disable iff (!i_rstn)
      (!i_run_position ##1 !i_run_position ##1 !i_run_position) |=> !o_run_halt_sense;
   endproperty
   a_halt: assert property (p_halt)
      else $error("Halt position not reported low on the fifth sense line.");

   // Rows follow a key closure three edges after the pin, against the count shown then.
   property p_key_rows;
      @(posedge i_mclk) disable iff (!i_rstn)
      ($past(i_rstn, 1) && $past(i_rstn, 2) && $past(i_rstn, 3) &&
       q.count < 4'(scan_pkg::KEY_COLS)) |->
      ({o_key_row_3, o_key_row_2, o_key_row_1, o_key_row_0} ==
       ~4'($past(i_key_closed, 3) >> {q.count[2:0], 2'b00}));
   endproperty
   a_key_rows: assert property (p_key_rows)
      else $error("Row sense does not match the closed key of the selected column.");

   // Anode pins reach the segment outputs three edges later, high meaning lit.
   property p_anode;
      @(posedge i_mclk) disable iff (!i_rstn)
      ($past(i_rstn, 1) && $past(i_rstn, 2) && $past(i_rstn, 3)) |->
      o_segment_anode == $past({i_anode_line_a, i_anode_line_b, i_anode_line_c,
                                i_anode_line_d, i_anode_line_e, i_anode_line_f,
                                i_anode_line_g}, 3);
   endproperty
   a_anode: assert property (p_anode)
      else $error("Segment anodes do not follow the anode lines.");

   // The mode LEDs share the five upper anode lines with segments A to E.
   property p_led_anode;
      @(posedge i_mclk) disable iff (!i_rstn)
      ($past(i_rstn, 1) && $past(i_rstn, 2) && $past(i_rstn, 3)) |->
      o_led_anode == $past({i_anode_line_a, i_anode_line_b, i_anode_line_c,
                            i_anode_line_d, i_anode_line_e}, 3);
   endproperty
   a_led_anode: assert property (p_led_anode)
      else $error("Mode LED anodes do not follow anode lines a to e.");

   // The count may only move on a step edge or a timeout, never on its own.
   property p_count_event;
      @(posedge i_mclk) disable iff (!i_rstn)
      (q.count != $past(q.count)) |-> ($past(evt.step_rise) || $past(evt.time_out));
   endproperty
   a_count_event: assert property (p_count_event)
      else $error("Scan count changed without a step edge or timeout.");

   // A held-high step line must give exactly one advance, not one per clock.
   property p_step_once;
      @(posedge i_mclk) disable iff (!i_rstn)
      evt.step_rise |=> !evt.step_rise;
   endproperty
   a_step_once: assert property (p_step_once)
      else $error("One step edge produced more than one advance.");

   // The idle timer fires once per idle spell; only a step edge rearms it.
   property p_tmo_pulse;
      @(posedge i_mclk) disable iff (!i_rstn)
      evt.time_out |=> !evt.time_out;
   endproperty
   a_tmo_pulse: assert property (p_tmo_pulse)
      else $error("Timeout fired on two cycles in a row.");

   // While parked at 15 no digit or LED cathode may sink current.
   property p_dark;
      @(posedge i_mclk) disable iff (!i_rstn)
      (q.count == scan_pkg::COUNT_LAST) |-> &o_scan_output_n[9:0];
   endproperty
   a_dark: assert property (p_dark)
      else $error("A cathode is selected while the scan is parked.");

   // Wrapping into count 0 must drop the origin flag together with the first column.
   property p_wrap_origin;
      @(posedge i_mclk) disable iff (!i_rstn)
      (evt.step_rise && !evt.time_out && q.count == scan_pkg::COUNT_LAST) |=>
      (!o_scan_output_n[0] && !o_scan_origin_flag);
   endproperty
   a_wrap_origin: assert property (p_wrap_origin)
      else $error("Origin flag not low after wrapping to count 0.");

   // The LED common cathode stays off on every count but 9.
   property p_led_dark;
      @(posedge i_mclk) disable iff (!i_rstn)
      (q.count != scan_pkg::COUNT_LED) |-> o_scan_output_n[scan_pkg::COUNT_LED];
   endproperty
   a_led_dark: assert property (p_led_dark)
      else $error("LED common cathode active on a count other than 9.");

endmodule
`default_nettype wire

// ===== keypad_display_scanner_tb.sv
`timescale 1ns/1ps
`default_nettype none
module keypad_display_scanner_tb;
   localparam int unsigned IDLE = 40;
   logic        i_mclk;
   logic        i_rstn;
   logic        i_run_position;
   logic [31:0] i_key_closed;
   logic        step;
   logic [6:0]  anode;
   logic [3:0]  rows;
   logic        o_run_halt_sense;
   logic        o_scan_origin_flag;
   logic [15:0] o_scan_output_n;
   logic [6:0]  o_segment_anode;
   logic [4:0]  o_led_anode;
   logic [31:0] rnd;
   logic [3:0]  cnt;
   int          n_errors;
   int          tests_run;

   host_port_model host_port_model_i (.o_step(step), .o_anode(anode));

   // A short idle limit keeps the timeout scenario within a few hundred cycles.
   keypad_display_scanner #(.IDLE_LIMIT(IDLE)) keypad_display_scanner_i (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_scan_step_line(step),
      .i_anode_line_a(anode[6]), .i_anode_line_b(anode[5]), .i_anode_line_c(anode[4]),
      .i_anode_line_d(anode[3]), .i_anode_line_e(anode[2]), .i_anode_line_f(anode[1]),
      .i_anode_line_g(anode[0]), .i_key_closed(i_key_closed),
      .i_run_position(i_run_position), .o_key_row_0(rows[0]), .o_key_row_1(rows[1]),
      .o_key_row_2(rows[2]), .o_key_row_3(rows[3]), .o_run_halt_sense(o_run_halt_sense),
      .o_scan_origin_flag(o_scan_origin_flag), .o_scan_output_n(o_scan_output_n),
      .o_segment_anode(o_segment_anode), .o_led_anode(o_led_anode));

   // Free-running 200 MHz clock.
   initial
   begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // Active-low one-hot select for a count.
   function automatic logic [15:0] exp_scan(input logic [3:0] c);
      return ~(16'h0001 << c);
   endfunction

   // Only counts 0 to 7 drive a keypad column; other counts leave every row high.
   function automatic logic [3:0] exp_rows(input logic [3:0] c, input logic [31:0] k);
      return (c < 4'h8) ? ~k[{c[2:0], 2'b00} +: 4] : 4'hF;
   endfunction

   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_vec(16'(got), 16'(exp));
   endtask

   task automatic check_all(input logic [3:0] c);
      chk_vec(o_scan_output_n, exp_scan(c));
      chk_bit(o_scan_origin_flag, c != 4'h0);
      chk_vec(16'(rows), 16'(exp_rows(c, i_key_closed)));
      chk_bit(o_run_halt_sense, i_run_position);
      chk_vec(16'(o_segment_anode), 16'(anode));
      chk_vec(16'(o_led_anode), 16'(anode[6:2]));
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // A hang beyond about fourteen times the expected run is counted as a failure.
   initial
   begin
      #50000;
      n_errors++;
      end_sim;
   end

   // Reset, a long random scan with wraps, then an idle spell and recovery.
   initial
   begin
      i_rstn = 1'b0;
      i_key_closed = 32'h0;
      i_run_position = 1'b1;
      rnd = 32'h9D9EDD63;
      n_errors = 0;
      tests_run = 0;
      repeat (10) @(posedge i_mclk);
      #1 chk_vec(o_scan_output_n, scan_pkg::SCAN_RESET_N);
      i_rstn = 1'b1;
      repeat (5) @(posedge i_mclk);
      #1 check_all(4'hF);
      $display("test reset done");
      cnt = 4'hF;
      for (int i = 0; i < 40; i++)
      begin
         rnd = xorshift(rnd);
         @(posedge i_mclk);
         #1 i_key_closed = (rnd[7:5] == 3'h0) ? 32'h0 : (32'h1 << rnd[4:0]);
         if (i == 3)
            i_key_closed = 32'h0000_1000;
         i_run_position = rnd[8];
         host_port_model_i.show(rnd[15:9]);
         host_port_model_i.step(1);
         cnt = cnt + 4'h1;
         repeat (4) @(posedge i_mclk);
         #1 check_all(cnt);
      end
      $display("test scan done");
      // The count rests at 7 here, so parking at 15 is a real change.
      repeat (IDLE + 20) @(posedge i_mclk);
      #1 check_all(4'hF);
      repeat (IDLE) @(posedge i_mclk);
      #1 check_all(4'hF);
      host_port_model_i.step(1);
      repeat (4) @(posedge i_mclk);
      #1 check_all(4'h0);
      $display("test timeout done");
      end_sim;
   end
endmodule
`default_nettype wire

// ===== scan_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Events from the step-line watcher to the scan counter.
interface scan_evt_if;
   logic step_rise;
   logic time_out;
   modport src (output step_rise, output time_out);
   modport dst (input step_rise, input time_out);
endinterface
`default_nettype wire

// ===== step_watch.sv
`timescale 1ns/1ps
`default_nettype none
// Samples the step line, finds its rising edges and times inactivity.
module step_watch #(
   parameter int unsigned IDLE_LIMIT = scan_pkg::IDLE_TIMEOUT_CYC
) (
   input  wire logic   i_mclk,
   input  wire logic   i_rstn,
   input  wire logic   i_step_line,
   scan_evt_if.src     evt
);

   typedef struct packed {
      logic                        s1;
      logic                        s2;
      logic                        s3;
      logic [scan_pkg::IDLE_W-1:0] idle;
      logic                        parked;
      logic                        rise;
      logic                        tmo;
   } watch_t;

   watch_t q;
   watch_t d;

   // Edge found between the second and third stage; the first stage is only resynchronised.
   always_comb
   begin
      d      = q;
      d.s1   = i_step_line;
      d.s2   = q.s1;
      d.s3   = q.s2;
      d.rise = q.s2 & ~q.s3;
      d.tmo  = 1'b0;
      if (d.rise)
      begin
         d.idle   = '0;
         d.parked = 1'b0;
      end
      else if (!q.parked)
      begin
         // The timer stops once parked so the timeout fires a single time per idle spell.
         if (q.idle == scan_pkg::IDLE_W'(IDLE_LIMIT - 1))
         begin
            d.tmo    = 1'b1;
            d.parked = 1'b1;
         end
         else
         begin
            d.idle = scan_pkg::IDLE_W'(q.idle + 1'b1);
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign evt.step_rise = q.rise;
   assign evt.time_out  = q.tmo;

endmodule
`default_nettype wire
